/* File: status_flags_pkg.sv */
// Constants, register map and carrier types for the multi-processor status flag bank
// How it works
// R1 - Any blown output fuse sets fuse flag
// R2 - Fuse flag stays set after fault clears
// R3 - Clock fault flag follows clock word check
// R4 - Slot ready flag follows bus readiness
// R5 - Slot reset flag follows processor reset
// R6 - Slot error flag set on stop error
// R7 - Continuation error or normal keeps flag clear
// R8 - Clock check evaluated only on user request
// R9 - Flags reset clear; writes have no effect
package status_flags_pkg;

  localparam int unsigned NUM_SLOTS = 4;
  localparam int unsigned ADDR_W = 12;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h00c;

  // Status word field positions
  localparam int unsigned BIT_FUSE = 0;
  localparam int unsigned BIT_CLOCK = 1;
  localparam int unsigned POS_READY = 4;
  localparam int unsigned POS_RESET = 8;
  localparam int unsigned POS_STOP = 12;
  localparam int unsigned STATUS_W = 16;

  // Control word field positions
  localparam int unsigned BIT_CHECK_REQ = 0;
  localparam int unsigned BIT_FUSE_CLEAR = 1;

  // Reset values
  localparam logic [STATUS_W-1:0] STATUS_RESET = 16'h0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Clock data check: month and day ranges on word0, hour and minute on word3
  localparam logic [7:0] MONTH_MIN = 8'h01;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] DAY_MIN = 8'h01;
  localparam logic [7:0] DAY_MAX = 8'h31;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] MINUTE_MAX = 8'h59;

  // Condition inputs from each processor slot
  typedef struct packed {
    logic bus_ready;
    logic in_reset;
    logic stop_error;
    logic cont_error;
  } slot_cond_s;

  // Flags reported back for each slot
  typedef struct packed {
    logic bus_ready;
    logic in_reset;
    logic stop_fault;
  } slot_flags_s;

  typedef slot_cond_s [NUM_SLOTS-1:0] slot_cond_t;
  typedef slot_flags_s [NUM_SLOTS-1:0] slot_flags_t;

endpackage

/* File: multi_cpu_status_flags.sv */
// Status flag bank with APB slave, sticky interrupt status and per-slot processor flags
`timescale 1ns/1ps
`default_nettype none

module multi_cpu_status_flags
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [status_flags_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Conditions from outside the clock domain
  input wire logic [status_flags_pkg::NUM_SLOTS-1:0] fuse_blown_in,
  input wire status_flags_pkg::slot_cond_t slot_cond_in,
  // Clock data words from the calendar, same clock domain
  input wire logic [15:0] clock_data_word0,
  input wire logic [15:0] clock_data_word3,
  // Flag outputs
  output logic fuse_blown_latch,
  output logic clock_data_fault,
  output status_flags_pkg::slot_flags_t slot_flags,
  output logic irq
);
  import status_flags_pkg::*;

  localparam int unsigned COND_W = $bits(slot_cond_t);

  logic [NUM_SLOTS-1:0] fuse_meta_q;
  logic [NUM_SLOTS-1:0] fuse_sync_q;
  logic [COND_W-1:0] cond_meta_q;
  slot_cond_t cond_sync_q;
  logic fuse_q;
  logic clock_q;
  logic [NUM_SLOTS-1:0] ready_q;
  logic [NUM_SLOTS-1:0] reset_q;
  logic [NUM_SLOTS-1:0] stop_q;
  logic [STATUS_W-1:0] status_w;
  logic [STATUS_W-1:0] status_prev_q;
  logic [STATUS_W-1:0] irq_stat_q;
  logic [STATUS_W-1:0] irq_mask_q;
  logic [STATUS_W-1:0] rise_w;
  logic check_req_w;
  logic fuse_clear_w;
  logic clock_bad_w;
  logic wr_access;
  logic rd_access;
  logic [31:0] rdata_d;
  logic addr_ok_w;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for external conditions
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fuse_meta_q <= '0;
      fuse_sync_q <= '0;
      cond_meta_q <= '0;
      cond_sync_q <= '0;
    end
    else
    begin
      fuse_meta_q <= fuse_blown_in;
      fuse_sync_q <= fuse_meta_q;
      cond_meta_q <= slot_cond_in;
      cond_sync_q <= cond_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && !penable && !pwrite;
  assign check_req_w = wr_access && (paddr == OFS_CONTROL) && pstrb[0] && pwdata[BIT_CHECK_REQ];
  assign fuse_clear_w = wr_access && (paddr == OFS_CONTROL) && pstrb[0]
                        && pwdata[BIT_FUSE_CLEAR];

  // Address check for the error answer
  always_comb
  begin
    if (paddr == OFS_STATUS)
      addr_ok_w = 1'b1;
    else if (paddr == OFS_IRQ_STATUS)
      addr_ok_w = 1'b1;
    else if (paddr == OFS_IRQ_MASK)
      addr_ok_w = 1'b1;
    else if (paddr == OFS_CONTROL)
      addr_ok_w = 1'b1;
    else
      addr_ok_w = 1'b0;
  end

  // Read mux; the status word is read-only, writes to it are dropped
  always_comb
  begin
    rdata_d = WORD_ZERO;
    if (paddr == OFS_STATUS)
      rdata_d[STATUS_W-1:0] = status_w; // R9
    else if (paddr == OFS_IRQ_STATUS)
      rdata_d[STATUS_W-1:0] = irq_stat_q;
    else if (paddr == OFS_IRQ_MASK)
      rdata_d[STATUS_W-1:0] = irq_mask_q;
    else
      rdata_d = WORD_ZERO;
  end

  // Answer one cycle after setup: data and ready registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= WORD_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok_w;
      if (rd_access)
        prdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fuse latch: set by any blown fuse, cleared only by explicit software clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fuse_q <= 1'b0; // R9
    else if (|fuse_sync_q)
      fuse_q <= 1'b1; // R1 R2
    else if (fuse_clear_w)
      fuse_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock data check, sampled only on a user request
  always_comb
  begin
    clock_bad_w = 1'b0;
    if (clock_data_word0[15:8] < MONTH_MIN || clock_data_word0[15:8] > MONTH_MAX)
      clock_bad_w = 1'b1;
    else if (clock_data_word0[7:0] < DAY_MIN || clock_data_word0[7:0] > DAY_MAX)
      clock_bad_w = 1'b1;
    else if (clock_data_word3[15:8] > HOUR_MAX || clock_data_word3[7:0] > MINUTE_MAX)
      clock_bad_w = 1'b1;
    else
      clock_bad_w = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clock_q <= 1'b0;
    else if (check_req_w)
      clock_q <= clock_bad_w; // R3 R8
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-slot processor flags
  for (genvar i = 0; i < NUM_SLOTS; i++)
  begin : g_slot
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        ready_q[i] <= 1'b0;
        reset_q[i] <= 1'b0;
        stop_q[i] <= 1'b0;
      end
      else
      begin
        ready_q[i] <= cond_sync_q[i].bus_ready; // R4
        reset_q[i] <= cond_sync_q[i].in_reset; // R5
        stop_q[i] <= cond_sync_q[i].stop_error; // R6 R7
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word and rising-edge events
  always_comb
  begin
    status_w = STATUS_RESET;
    status_w[BIT_FUSE] = fuse_q;
    status_w[BIT_CLOCK] = clock_q;
    status_w[POS_READY +: NUM_SLOTS] = ready_q;
    status_w[POS_RESET +: NUM_SLOTS] = reset_q;
    status_w[POS_STOP +: NUM_SLOTS] = stop_q;
  end

  assign rise_w = status_w & ~status_prev_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_prev_q <= STATUS_RESET;
    else
      status_prev_q <= status_w;
  end

  // Sticky event bits, write one to clear, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_q <= STATUS_RESET;
    else if (wr_access && paddr == OFS_IRQ_STATUS)
      irq_stat_q <= (irq_stat_q & ~pwdata[STATUS_W-1:0]) | rise_w;
    else
      irq_stat_q <= irq_stat_q | rise_w;
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_q <= STATUS_RESET;
    else if (wr_access && paddr == OFS_IRQ_MASK)
      irq_mask_q <= pwdata[STATUS_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered flag outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fuse_blown_latch <= 1'b0;
      clock_data_fault <= 1'b0;
      slot_flags <= '0;
      irq <= 1'b0;
    end
    else
    begin
      fuse_blown_latch <= fuse_q;
      clock_data_fault <= clock_q;
      for (int k = 0; k < NUM_SLOTS; k++)
      begin
        slot_flags[k].bus_ready <= ready_q[k];
        slot_flags[k].in_reset <= reset_q[k];
        slot_flags[k].stop_fault <= stop_q[k];
      end
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_fuse_set;
    @(posedge pclk) disable iff (!presetn)
    (|fuse_sync_q) |=> fuse_q;
  endproperty
  a_fuse_set: assert property (p_fuse_set) else $error("fuse flag not set"); // R1

  property p_fuse_hold;
    @(posedge pclk) disable iff (!presetn)
    (fuse_q && !fuse_clear_w) |=> fuse_q;
  endproperty
  a_fuse_hold: assert property (p_fuse_hold) else $error("fuse flag dropped"); // R2

  property p_clock_eval;
    @(posedge pclk) disable iff (!presetn)
    check_req_w |=> (clock_q == $past(clock_bad_w));
  endproperty
  a_clock_eval: assert property (p_clock_eval) else $error("clock check wrong"); // R3

  property p_clock_stable;
    @(posedge pclk) disable iff (!presetn)
    !check_req_w |=> $stable(clock_q);
  endproperty
  a_clock_stable: assert property (p_clock_stable) else $error("clock flag moved"); // R8

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> ready_q == $past({cond_sync_q[3].bus_ready, cond_sync_q[2].bus_ready,
                               cond_sync_q[1].bus_ready, cond_sync_q[0].bus_ready});
  endproperty
  a_ready: assert property (p_ready) else $error("ready flag mismatch"); // R4

  property p_reset_out;
    @(posedge pclk) disable iff (!presetn)
    reset_q[1] |=> slot_flags[1].in_reset;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset flag not shown"); // R5

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
    cond_sync_q[2].stop_error |=> stop_q[2] ##1 slot_flags[2].stop_fault;
  endproperty
  a_stop: assert property (p_stop) else $error("stop flag not set"); // R6

  property p_cont_normal;
    @(posedge pclk) disable iff (!presetn)
    !cond_sync_q[3].stop_error |=> !stop_q[3];
  endproperty
  a_cont_normal: assert property (p_cont_normal) else $error("stop flag on normal"); // R7

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    (|(irq_stat_q & irq_mask_q)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised"); // irq output, not covered by R1 to R9

  property p_flags_reset;
    @(posedge pclk)
    !presetn |=> (!fuse_blown_latch && !clock_data_fault && slot_flags == '0 && !irq);
  endproperty
  a_flags_reset: assert property (p_flags_reset) else $error("flags not clear in reset"); // R9

  property p_status_ro;
    @(posedge pclk) disable iff (!presetn)
    (wr_access && paddr == OFS_STATUS) |=> $stable(irq_mask_q) && $stable(clock_q);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write had an effect"); // R9

  property p_fuse_out;
    @(posedge pclk) disable iff (!presetn)
    fuse_q |=> fuse_blown_latch;
  endproperty
  a_fuse_out: assert property (p_fuse_out) else $error("fuse flag not shown"); // R1

  property p_clock_out;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> clock_data_fault == $past(clock_q);
  endproperty
  a_clock_out: assert property (p_clock_out) else $error("clock flag not shown"); // R3

  property p_reset_clear;
    @(posedge pclk) disable iff (!presetn)
    !cond_sync_q[0].in_reset |=> !reset_q[0];
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset flag stuck"); // R5

  property p_stop_out;
    @(posedge pclk) disable iff (!presetn)
    stop_q[0] |=> slot_flags[0].stop_fault;
  endproperty
  a_stop_out: assert property (p_stop_out) else $error("stop flag not shown"); // R6

endmodule

`default_nettype wire

/* File: proc_slots_model.sv */
// Behavioural model of the four cooperating processors
`timescale 1ns/1ps
`default_nettype none

module proc_slots_model
(
  // Per-slot commands from the bench
  input wire logic [3:0] ready_cmd,
  input wire logic [3:0] reset_cmd,
  input wire logic [3:0] stop_cmd,
  input wire logic [3:0] cont_cmd,
  // Conditions towards the flag bank
  output status_flags_pkg::slot_cond_t slot_cond
);
  import status_flags_pkg::*;

  // A processor held in reset cannot be ready on the shared bus
  always_comb
  begin
    for (int i = 0; i < NUM_SLOTS; i++)
    begin
      slot_cond[i].bus_ready = ready_cmd[i] & ~reset_cmd[i];
      slot_cond[i].in_reset = reset_cmd[i];
      slot_cond[i].stop_error = stop_cmd[i];
      slot_cond[i].cont_error = cont_cmd[i];
    end
  end
endmodule

`default_nettype wire

/* File: tb_multi_cpu_status_flags.sv */
// Self-checking bench for the multi-processor status flag bank
`timescale 1ns/1ps
`default_nettype none

module tb_multi_cpu_status_flags;
  import status_flags_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] fuse_blown_in = 4'h0;
  slot_cond_t slot_cond_in;
  logic [15:0] word0 = 16'h0101;
  logic [15:0] word3 = 16'h0000;
  logic fuse_blown_latch;
  logic clock_data_fault;
  slot_flags_t slot_flags;
  logic irq;
  logic [3:0] ready_cmd = 4'h0;
  logic [3:0] reset_cmd = 4'h0;
  logic [3:0] stop_cmd = 4'h0;
  logic [3:0] cont_cmd = 4'h0;
  logic [31:0] rd;
  logic er;
  int errors = 0;
  int checked = 0;
  int cyc = 0;

  ////////////////////////////////////////////////////////////////////
  multi_cpu_status_flags dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fuse_blown_in(fuse_blown_in),
    .slot_cond_in(slot_cond_in), .clock_data_word0(word0), .clock_data_word3(word3),
    .fuse_blown_latch(fuse_blown_latch), .clock_data_fault(clock_data_fault),
    .slot_flags(slot_flags), .irq(irq));
  proc_slots_model model_u (.ready_cmd(ready_cmd), .reset_cmd(reset_cmd),
    .stop_cmd(stop_cmd), .cont_cmd(cont_cmd), .slot_cond(slot_cond_in));

  // Clock and hang guard
  always #10 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; waits for pready with the request held
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never reassigns psel in this time step
    @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({fuse_blown_latch, clock_data_fault, slot_flags, irq}, 32'h0);
    apb(1'b1, OFS_STATUS, 32'hffff_ffff);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask

  task automatic t_fuse();
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    fuse_blown_in <= 4'h4;
    waitc(6);
    chk({31'h0, fuse_blown_latch}, 32'h1);
    fuse_blown_in <= 4'h0;
    waitc(6);
    chk({30'h0, fuse_blown_latch, irq}, 32'h2);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    waitc(3);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_IRQ_STATUS, 32'h1);
    waitc(3);
    chk({30'h0, fuse_blown_latch, irq}, 32'h2);
    // Software clear loses to a fuse still blown, works once it is gone
    fuse_blown_in <= 4'h1;
    waitc(6);
    apb(1'b1, OFS_CONTROL, 32'h2);
    waitc(3);
    chk({31'h0, fuse_blown_latch}, 32'h1);
    fuse_blown_in <= 4'h0;
    waitc(6);
    apb(1'b1, OFS_CONTROL, 32'h2);
    waitc(3);
    chk({31'h0, fuse_blown_latch}, 32'h0);
  endtask

  task automatic t_clock();
    word0 <= 16'h1301;
    word3 <= 16'h1000;
    waitc(6);
    chk({31'h0, clock_data_fault}, 32'h0);
    apb(1'b1, OFS_CONTROL, 32'h1);
    waitc(6);
    chk({31'h0, clock_data_fault}, 32'h1);
    word0 <= 16'h1231;
    word3 <= 16'h2359;
    waitc(6);
    chk({31'h0, clock_data_fault}, 32'h1);
    apb(1'b1, OFS_CONTROL, 32'h1);
    waitc(6);
    chk({31'h0, clock_data_fault}, 32'h0);
    // Hour out of range in the second word
    word3 <= 16'h2400;
    apb(1'b1, OFS_CONTROL, 32'h1);
    waitc(3);
    chk({31'h0, clock_data_fault}, 32'h1);
  endtask

  // Commands one slot as {ready, reset, stop, continue} and checks its flags
  task automatic step(input int i, input logic [3:0] c, input logic [2:0] e);
    ready_cmd[i] <= c[3];
    reset_cmd[i] <= c[2];
    stop_cmd[i] <= c[1];
    cont_cmd[i] <= c[0];
    waitc(6);
    chk({29'h0, slot_flags[i]}, {29'h0, e});
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({29'h0, rd[4+i], rd[8+i], rd[12+i]}, {29'h0, e});
  endtask

  task automatic t_slots();
    for (int i = 0; i < 4; i++)
    begin
      step(i, 4'b1000, 3'b100);
      step(i, 4'b1100, 3'b010);
      step(i, 4'b1010, 3'b101);
      step(i, 4'b1001, 3'b100);
      step(i, 4'b0000, 3'b000);
    end
  endtask

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_fuse();
    t_clock();
    t_slots();
    results();
  end
endmodule

`default_nettype wire
